// ==== src/sru_shift_unit.sv ====
// Purpose: shift and rotate datapath for the two accumulators
// Assumes: caller loads operands with start and waits for done
// Notes:   one position is shifted per paced step, so the result
//          appears exactly when the documented time has passed
`timescale 1ns/1ns
`include "sru_cfg.svh"

module sru_shift_unit #(
    parameter int UNIT_TICKS = `SRU_CPU_CYCLE_NS / (`SRU_PARTS_PER_CYCLE * `SRU_CLK_NS)
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic indexed_in,
    input wire logic [`SRU_FIELD_W-1:0] instr_in,
    input wire logic [`SRU_FIELD_W-1:0] index_in,
    input wire logic [`SRU_WORD_W-1:0] acc_a_in,
    input wire logic [`SRU_WORD_W-1:0] acc_b_in,
    input wire logic ovf_in,
    output logic [`SRU_WORD_W-1:0] acc_a_out,
    output logic [`SRU_WORD_W-1:0] acc_b_out,
    output logic ovf_out,
    output logic busy_out,
    output logic done_out
);
    localparam int W = `SRU_WORD_W;

    // ====================================================
    // Parameter checks
    generate
        if (UNIT_TICKS < 1 || UNIT_TICKS * `SRU_PARTS_PER_CYCLE >= (1 << `SRU_TMR_W)
            || UNIT_TICKS * `SRU_WORST_PARTS >= (1 << `SRU_LAT_W)) begin : g_bad_unit
            $error("UNIT_TICKS out of range for timer or latency counter");
        end
    endgenerate

    localparam logic [`SRU_TMR_W-1:0] UNIT_T = `SRU_TMR_W'(UNIT_TICKS);
    localparam logic [`SRU_TMR_W-1:0] BASE_PARTS = `SRU_TMR_W'(`SRU_BASE_TENTHS / `SRU_PART_TENTHS);

    // ====================================================
    // Single position step, returns {flag, first acc, second acc}
    function automatic logic [2*W:0] step_fn(input sru_pkg::sru_op_t op, input logic [W-1:0] a,
                                             input logic [W-1:0] b, input logic v);
        logic [2*W:0] r;
        r = {v, a, b};
        case (op)
            sru_pkg::LOGICAL_LEFT_FIRST_ACC: r = {a[W-1], a[W-2:0], 1'h0, b};
            sru_pkg::LOGICAL_LEFT_SECOND_ACC: r = {b[W-1], a, b[W-2:0], 1'h0};
            sru_pkg::LOGICAL_LEFT_PAIR: r = {a[W-1], a[W-2:0], b[W-1], b[W-2:0], 1'h0};
            sru_pkg::LOGICAL_RIGHT_FIRST_ACC: r = {a[0], 1'h0, a[W-1:1], b};
            sru_pkg::LOGICAL_RIGHT_SECOND_ACC: r = {b[0], a, 1'h0, b[W-1:1]};
            sru_pkg::LOGICAL_RIGHT_PAIR: r = {b[0], 1'h0, a[W-1:1], a[0], b[W-1:1]};
            sru_pkg::ROTATE_LEFT_FIRST_ACC: r = {a[W-1], a[W-2:0], a[W-1], b};
            sru_pkg::ROTATE_LEFT_SECOND_ACC: r = {b[W-1], a, b[W-2:0], b[W-1]};
            sru_pkg::ROTATE_LEFT_PAIR: r = {a[W-1], a[W-2:0], b[W-1], b[W-2:0], a[W-1]};
            // Loss is a bit below the sign that differs from it
            sru_pkg::ARITH_LEFT_FIRST_ACC:
                r = {v | (a[W-1] ^ a[W-2]), a[W-1], a[W-3:0], 1'h0, b};
            sru_pkg::ARITH_LEFT_SECOND_ACC:
                r = {v | (b[W-1] ^ b[W-2]), a, b[W-1], b[W-3:0], 1'h0};
            sru_pkg::ARITH_LEFT_PAIR:
                r = {v | (a[W-1] ^ a[W-2]), a[W-1], a[W-3:0], b[W-2], 1'h0, b[W-3:0], 1'h0};
            sru_pkg::ARITH_RIGHT_FIRST_ACC: r = {1'h0, a[W-1], a[W-1:1], b};
            sru_pkg::ARITH_RIGHT_SECOND_ACC: r = {1'h0, a, b[W-1], b[W-1:1]};
            sru_pkg::ARITH_RIGHT_PAIR: r = {1'h0, a[W-1], a[W-1:1], b[W-1], a[0], b[W-2:1]};
            default: r = {v, a, b};
        endcase
        return r;
    endfunction

    // ====================================================
    // State and datapath registers
    sru_pkg::sru_state_t state_reg;
    sru_pkg::sru_state_t state_next;
    logic [W-1:0] a_reg;
    logic [W-1:0] b_reg;
    logic ovf_reg;
    logic [`SRU_FIELD_W-1:0] field_reg;
    logic [`SRU_CNT_MSB:0] left_reg;
    logic busy_reg;
    logic done_reg;

    sru_ctl_if ctl ();

    wire accept;
    wire [`SRU_FIELD_W-1:0] field_sum;
    wire base_end;
    wire go_steps;
    wire step_end;
    wire last_step;
    wire finish;
    wire clears_flag;
    wire [2*W:0] step_res;

    // ====================================================
    // Sub-blocks: field decode and pacing timer
    sru_decode u_decode (
        .ctl(ctl.decoder)
    );

    sru_timer u_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ctl(ctl.timer)
    );

    // ====================================================
    // Request take-over and effective field
    assign accept = (state_reg == sru_pkg::ST_IDLE) && start_in;
    // Nine-bit sum wraps, carry out of the field is dropped
    assign field_sum = indexed_in ? `SRU_FIELD_W'(instr_in + index_in) : instr_in;
    assign ctl.field = field_reg;

    // Phase ends and step bookkeeping
    assign base_end = (state_reg == sru_pkg::ST_BASE) && ctl.tmr_expire;
    assign go_steps = ctl.legal && (ctl.count != '0);
    assign step_end = (state_reg == sru_pkg::ST_STEP) && ctl.tmr_expire;
    assign last_step = left_reg == {{`SRU_CNT_MSB{1'h0}}, 1'h1};
    assign finish = (base_end && !go_steps) || (step_end && last_step);

    // Arithmetic kinds start from a clear flag
    assign clears_flag = ctl.op inside {sru_pkg::ARITH_LEFT_FIRST_ACC, sru_pkg::ARITH_LEFT_SECOND_ACC,
                                        sru_pkg::ARITH_LEFT_PAIR, sru_pkg::ARITH_RIGHT_FIRST_ACC,
                                        sru_pkg::ARITH_RIGHT_SECOND_ACC, sru_pkg::ARITH_RIGHT_PAIR};
    assign step_res = step_fn(ctl.op, a_reg, b_reg, ovf_reg);

    // Timer loads: base time at take-over, one cost per position later
    assign ctl.tmr_load = accept || (base_end && go_steps) || (step_end && !last_step);
    assign ctl.tmr_len = accept ? `SRU_TMR_W'(UNIT_T * BASE_PARTS)
                                : `SRU_TMR_W'(UNIT_T * `SRU_TMR_W'(ctl.parts));

    // ====================================================
    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            sru_pkg::ST_IDLE: begin
                if (start_in) begin
                    state_next = sru_pkg::ST_BASE;
                end
            end
            sru_pkg::ST_BASE: begin
                if (ctl.tmr_expire) begin
                    state_next = go_steps ? sru_pkg::ST_STEP : sru_pkg::ST_IDLE;
                end
            end
            sru_pkg::ST_STEP: begin
                if (ctl.tmr_expire && last_step) begin
                    state_next = sru_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg <= sru_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Operands; a start while busy is ignored, operands are held
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            a_reg <= '0;
            b_reg <= '0;
            ovf_reg <= 1'h0;
            field_reg <= '0;
        end else if (accept) begin
            a_reg <= acc_a_in;
            b_reg <= acc_b_in;
            ovf_reg <= ovf_in;
            field_reg <= field_sum;
        end else if (base_end && clears_flag) begin
            ovf_reg <= 1'h0;
        end else if (step_end) begin
            {ovf_reg, a_reg, b_reg} <= step_res;
        end
    end

    // Remaining positions
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            left_reg <= '0;
        end else if (base_end) begin
            left_reg <= ctl.count;
        end else if (step_end) begin
            left_reg <= left_reg - {{`SRU_CNT_MSB{1'h0}}, 1'h1};
        end
    end

    // Status flags
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            busy_reg <= 1'h0;
            done_reg <= 1'h0;
        end else begin
            busy_reg <= state_next != sru_pkg::ST_IDLE;
            done_reg <= finish;
        end
    end

    assign acc_a_out = a_reg;
    assign acc_b_out = b_reg;
    assign ovf_out = ovf_reg;
    assign busy_out = busy_reg;
    assign done_out = done_reg;

    // ====================================================
    // Checks: operand capture and latency helpers
    logic [W-1:0] cap_a;
    logic [W-1:0] cap_b;
    logic [`SRU_LAT_W-1:0] lat_cnt;
    wire [`SRU_LAT_W-1:0] exp_lat;
    wire [2*W-1:0] lsl_wide;
    wire [2*W-1:0] lsr_wide;
    wire [2*W-1:0] rol_wide;
    wire [4*W-1:0] rold_wide;
    wire [2*W-2:0] arith_right_pair_wide;
    wire [W-1:0] asr_word;
    wire nz;

    // Edges since the take; zero at the take so done lands on the cost
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cap_a <= '0;
            cap_b <= '0;
            lat_cnt <= '0;
        end else if (accept) begin
            cap_a <= acc_a_in;
            cap_b <= acc_b_in;
            lat_cnt <= `SRU_LAT_W'(0);
        end else if (busy_reg) begin
            lat_cnt <= lat_cnt + `SRU_LAT_W'(1);
        end
    end

    assign exp_lat = `SRU_LAT_W'(UNIT_TICKS) * (`SRU_LAT_W'(BASE_PARTS)
                     + (ctl.legal ? `SRU_LAT_W'(ctl.parts) * `SRU_LAT_W'(ctl.count) : '0));
    assign nz = ctl.count != '0;
    assign lsl_wide = {{W{1'h0}}, cap_a} << ctl.count;
    assign lsr_wide = {cap_a, {W{1'h0}}} >> ctl.count;
    assign rol_wide = {cap_a, cap_a} << ctl.count[3:0];
    assign rold_wide = {cap_a, cap_b, cap_a, cap_b} << ctl.count;
    assign arith_right_pair_wide = $signed({cap_a, cap_b[W-2:0]}) >>> ctl.count;
    assign asr_word = $signed(cap_a) >>> ctl.count;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence take_s;
        accept;
    endsequence

    sequence base_wait_s;
        (busy_out && !done_out) [*4];
    endsequence

    sequence result_s(sru_pkg::sru_op_t k);
        done_out && ctl.op == k && nz;
    endsequence

    // ====================================================
    // Assertions
    latency_exact_a: assert property (done_out |-> lat_cnt == exp_lat)
        else $error("completion time differs from base plus per-position cost");
    base_hold_a: assert property (take_s |-> ##1 base_wait_s)
        else $error("finished before the base cycle elapsed");
    zero_count_a: assert property (done_out && !nz |-> acc_a_out == cap_a && acc_b_out == cap_b)
        else $error("zero count changed an accumulator");
    index_sum_a: assert property (take_s ##0 indexed_in
        |=> ctl.field == `SRU_FIELD_W'($past(instr_in) + $past(index_in)))
        else $error("indexed field is not the nine-bit sum");
    lsl_first_a: assert property (result_s(sru_pkg::LOGICAL_LEFT_FIRST_ACC)
        |-> acc_a_out == lsl_wide[W-1:0] && ovf_out == lsl_wide[W])
        else $error("logical left of first accumulator wrong");
    lsr_first_a: assert property (result_s(sru_pkg::LOGICAL_RIGHT_FIRST_ACC)
        |-> acc_a_out == lsr_wide[2*W-1:W] && ovf_out == lsr_wide[W-1])
        else $error("logical right of first accumulator wrong");
    rol_first_a: assert property (result_s(sru_pkg::ROTATE_LEFT_FIRST_ACC)
        |-> acc_a_out == rol_wide[2*W-1:W] && ovf_out == acc_a_out[0])
        else $error("rotate of first accumulator wrong");
    rol_pair_a: assert property (result_s(sru_pkg::ROTATE_LEFT_PAIR)
        |-> {acc_a_out, acc_b_out} == rold_wide[4*W-1:2*W] && ovf_out == acc_b_out[0])
        else $error("double rotate wrong");
    asl_sign_a: assert property (result_s(sru_pkg::ARITH_LEFT_FIRST_ACC)
        |-> acc_a_out[W-1] == cap_a[W-1] && acc_a_out[0] == 1'h0)
        else $error("arithmetic left altered the sign");
    arith_left_pair_signs_a: assert property (result_s(sru_pkg::ARITH_LEFT_PAIR)
        |-> acc_a_out[W-1] == cap_a[W-1] && acc_b_out[W-1] == 1'h0)
        else $error("double arithmetic left sign handling wrong");
    asr_first_a: assert property (result_s(sru_pkg::ARITH_RIGHT_FIRST_ACC)
        |-> acc_a_out == asr_word && !ovf_out)
        else $error("arithmetic right of first accumulator wrong");
    arith_right_pair_pair_a: assert property (result_s(sru_pkg::ARITH_RIGHT_PAIR)
        |-> {acc_a_out, acc_b_out[W-2:0]} == arith_right_pair_wide && acc_b_out[W-1] == cap_b[W-1] && !ovf_out)
        else $error("double arithmetic right wrong");
endmodule // sru_shift_unit

// ==== src/sru_cfg.svh ====
// Behaviour
// - Logical left A: zeros in, flag takes last out
// - Logical left B: zeros in, flag takes last out
// - Double logical left: B sign into A low
// - Logical right A: zeros into sign, flag follows
// - Logical right B: zeros into sign, flag follows
// - Double logical right: A low into B sign
// - Rotate left A: sign recirculates, flag last bit
// - Rotate left B: sign recirculates, flag last bit
// - Double rotate: signs cross, flag B low
// - Arithmetic left A: sign kept, sticky loss flag
// - Arithmetic left B: sign kept, sticky loss flag
// - Double arithmetic left: B sign cleared, sticky flag
// - Arithmetic right A: sign replicated, flag cleared
// - Arithmetic right B: sign replicated, flag cleared
// - Double arithmetic right: A low below B sign
// - Counts 0..31, base cycle plus per-position cost
// - Code 700 octal is double rotate left
// - Codes 000..640 step 040 select operation
// - Indexed: add low nine index bits
// - Count field is separate five-bit field
//
// Purpose: constants of the shift and rotate unit
// Assumes: one processor cycle is split into fifths
// Notes:   times are in tenths of a processor cycle, cycle and clock periods in ns
`ifndef SRU_CFG_SVH
`define SRU_CFG_SVH

// ====================================================
// Word and instruction field layout
`define SRU_WORD_W 16
`define SRU_FIELD_W 9
`define SRU_TYPE_MSB 8
`define SRU_TYPE_LSB 5
`define SRU_CNT_MSB 4
`define SRU_CNT_LSB 0
`define SRU_TMR_W 8
`define SRU_LAT_W 10

// ====================================================
// Timing: tenths of a processor cycle, periods in ns, part counts in fifths
`define SRU_BASE_TENTHS 10
`define SRU_LIGHT_TENTHS 2
`define SRU_MID_TENTHS 4
`define SRU_HEAVY_TENTHS 6
`define SRU_PART_TENTHS 2
`define SRU_CPU_CYCLE_NS 250
`define SRU_CLK_NS 50
`define SRU_PARTS_PER_CYCLE 5
`define SRU_WORST_PARTS 98

`endif

// ==== src/sru_pkg.sv ====
// Purpose: shared types of the shift and rotate unit
// Assumes: codes are the shift type field divided by 040 octal
// Notes:   code 15 is unused and treated as a no-op
package sru_pkg;

    // ====================================================
    // Operation codes
    typedef enum logic [3:0] {
        ARITH_LEFT_FIRST_ACC = 4'h0,
        LOGICAL_LEFT_FIRST_ACC = 4'h1,
        ARITH_RIGHT_FIRST_ACC = 4'h2,
        LOGICAL_RIGHT_FIRST_ACC = 4'h3,
        ARITH_LEFT_SECOND_ACC = 4'h4,
        LOGICAL_LEFT_SECOND_ACC = 4'h5,
        ARITH_RIGHT_SECOND_ACC = 4'h6,
        LOGICAL_RIGHT_SECOND_ACC = 4'h7,
        ARITH_LEFT_PAIR = 4'h8,
        LOGICAL_LEFT_PAIR = 4'h9,
        ARITH_RIGHT_PAIR = 4'ha,
        LOGICAL_RIGHT_PAIR = 4'hb,
        ROTATE_LEFT_FIRST_ACC = 4'hc,
        ROTATE_LEFT_SECOND_ACC = 4'hd,
        ROTATE_LEFT_PAIR = 4'he,
        OP_UNDEFINED = 4'hf
    } sru_op_t;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_BASE = 3'h2,
        ST_STEP = 3'h4
    } sru_state_t;

endpackage

// ==== src/sru_ctl_if.sv ====
// Purpose: carries decode and timer signals inside the unit
// Assumes: all users share one clock
// Notes:   no clocking block, plain wires only
`timescale 1ns/1ns
`include "sru_cfg.svh"

interface sru_ctl_if;
    logic [`SRU_FIELD_W-1:0] field;
    sru_pkg::sru_op_t op;
    logic [`SRU_CNT_MSB:0] count;
    logic [1:0] parts;
    logic legal;
    logic tmr_load;
    logic [`SRU_TMR_W-1:0] tmr_len;
    logic tmr_expire;

    modport decoder (input field, output op, output count, output parts, output legal);
    modport timer (input tmr_load, input tmr_len, output tmr_expire);
    modport core (output field, output tmr_load, output tmr_len,
                  input op, input count, input parts, input legal, input tmr_expire);
endinterface // sru_ctl_if

// ==== src/sru_decode.sv ====
// Purpose: splits the effective nine-bit field into type and count
// Assumes: field already holds the index sum when indexed
// Notes:   parts are fifths of a cycle per shifted position
`timescale 1ns/1ns
`include "sru_cfg.svh"

module sru_decode (
    sru_ctl_if.decoder ctl
);
    wire heavy_op;
    wire mid_op;

    // ====================================================
    // Type and count fields
    assign ctl.op = sru_pkg::sru_op_t'(ctl.field[`SRU_TYPE_MSB:`SRU_TYPE_LSB]);
    assign ctl.count = ctl.field[`SRU_CNT_MSB:`SRU_CNT_LSB];
    assign ctl.legal = ctl.op != sru_pkg::OP_UNDEFINED;

    // Per-position cost classes
    assign heavy_op = ctl.op inside {sru_pkg::ROTATE_LEFT_PAIR, sru_pkg::ARITH_LEFT_PAIR};
    assign mid_op = ctl.op inside {sru_pkg::LOGICAL_LEFT_PAIR, sru_pkg::LOGICAL_RIGHT_PAIR,
                                   sru_pkg::ARITH_LEFT_FIRST_ACC, sru_pkg::ARITH_LEFT_SECOND_ACC,
                                   sru_pkg::ARITH_RIGHT_PAIR};
    assign ctl.parts = heavy_op ? 2'(`SRU_HEAVY_TENTHS / `SRU_PART_TENTHS) :
                       mid_op ? 2'(`SRU_MID_TENTHS / `SRU_PART_TENTHS) :
                       2'(`SRU_LIGHT_TENTHS / `SRU_PART_TENTHS);
endmodule // sru_decode

// ==== src/sru_timer.sv ====
// Purpose: down counter that paces base and per-position time
// Assumes: load is a one-cycle pulse, length at least one
// Notes:   expire is high one cycle, length cycles after load
`timescale 1ns/1ns
`include "sru_cfg.svh"

module sru_timer (
    input wire logic clk_in,
    input wire logic rst_n_in,
    sru_ctl_if.timer ctl
);
    logic [`SRU_TMR_W-1:0] cnt_reg;
    logic run_reg;

    // ====================================================
    // Expiry when the running count reaches zero
    assign ctl.tmr_expire = run_reg && (cnt_reg == `SRU_TMR_W'(0));

    // Reload wins over expiry so steps chain without gaps
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            run_reg <= 1'h0;
            cnt_reg <= `SRU_TMR_W'(0);
        end else if (ctl.tmr_load) begin
            run_reg <= 1'h1;
            cnt_reg <= ctl.tmr_len - `SRU_TMR_W'(1);
        end else if (ctl.tmr_expire) begin
            run_reg <= 1'h0;
        end else if (run_reg) begin
            cnt_reg <= cnt_reg - `SRU_TMR_W'(1);
        end
    end
endmodule // sru_timer

// ==== test/sru_cu_model.sv ====
// Purpose: instruction control side that issues shifts to the unit
// Assumes: issue is entered just after a rising clock edge
// Notes:   operand inputs are scrambled once the request is taken
`timescale 1ns/1ns

module sru_cu_model (
    input wire logic clk_in,
    input wire logic busy_in,
    input wire logic done_in,
    output logic start_out,
    output logic indexed_out,
    output logic [8:0] instr_out,
    output logic [8:0] index_out,
    output logic [15:0] acc_a_out,
    output logic [15:0] acc_b_out,
    output logic ovf_out
);
    // ==========================================
    // Idle values at time zero
    initial begin
        start_out = 1'b0;
        indexed_out = 1'b0;
        instr_out = 9'h000;
        index_out = 9'h000;
        acc_a_out = 16'h0000;
        acc_b_out = 16'h0000;
        ovf_out = 1'b0;
    end

    // One request, taken at the next edge, then wait for done
    task automatic issue(input logic idx, input logic [8:0] ins, input logic [8:0] ixr,
                         input logic [15:0] a, input logic [15:0] b, input logic v,
                         output int cycles, output logic busy_ok);
        int cnt;
        cnt = 0;
        busy_ok = 1'b1;
        start_out = 1'b1;
        indexed_out = idx;
        instr_out = ins;
        index_out = ixr;
        acc_a_out = a;
        acc_b_out = b;
        ovf_out = v;
        @(posedge clk_in);
        #1;
        // Inverted after the take so a late sample shows up
        start_out = 1'b0;
        acc_a_out = ~a;
        acc_b_out = ~b;
        ovf_out = ~v;
        instr_out = ~ins;
        index_out = ~ixr;
        while (cnt < 200 && done_in !== 1'b1) begin
            @(posedge clk_in);
            #1;
            cnt++;
            if (done_in !== 1'b1 && busy_in !== 1'b1) busy_ok = 1'b0;
        end
        cycles = cnt;
    endtask
endmodule // sru_cu_model

// ==== test/tb.sv ====
// Purpose: self-checking bench of the shift and rotate unit
// Assumes: one clock per fifth of a processor cycle
// Notes:   every code, boundary counts, indexed carry, back to back
`timescale 1ns/1ns

module tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic start, indexed, ovf_i, ovf_o, busy, done, busy_ok;
    logic [8:0] instr, index;
    logic [15:0] acc_a_i, acc_b_i, acc_a_o, acc_b_o;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [15:0] pa [3] = '{16'h9a53, 16'h4e71, 16'h0003};
    logic [15:0] pb [3] = '{16'h6c2d, 16'hb38c, 16'h0005};
    int cnts [4] = '{0, 1, 17, 31};

    // ==========================================
    // Clock and hang limit
    initial forever #25 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            wrap_up();
        end
    end

    sru_cu_model u_cu (.clk_in(clk_in), .busy_in(busy), .done_in(done), .start_out(start),
        .indexed_out(indexed), .instr_out(instr), .index_out(index), .acc_a_out(acc_a_i),
        .acc_b_out(acc_b_i), .ovf_out(ovf_i));

    sru_shift_unit #(.UNIT_TICKS(1)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start),
        .indexed_in(indexed), .instr_in(instr), .index_in(index), .acc_a_in(acc_a_i),
        .acc_b_in(acc_b_i), .ovf_in(ovf_i), .acc_a_out(acc_a_o), .acc_b_out(acc_b_o),
        .ovf_out(ovf_o), .busy_out(busy), .done_out(done));

    task automatic wrap_up();
        if (bad_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ==========================================
    // Step-by-step reference, one position at a time
    function automatic logic [32:0] ref_op(input logic [3:0] op, input int n, input logic [15:0] a,
                                           input logic [15:0] b, input logic v);
        logic loss;
        logic [15:0] t;
        loss = 1'b0;
        for (int i = 0; i < n; i++) begin
            t = a;
            case (op)
                4'h0: begin loss |= a[15] ^ a[14]; a = {a[15], a[13:0], 1'b0}; end
                4'h1: begin v = a[15]; a = a << 1; end
                4'h2: a = {a[15], a[15:1]};
                4'h3: begin v = a[0]; a = a >> 1; end
                4'h4: begin loss |= b[15] ^ b[14]; b = {b[15], b[13:0], 1'b0}; end
                4'h5: begin v = b[15]; b = b << 1; end
                4'h6: b = {b[15], b[15:1]};
                4'h7: begin v = b[0]; b = b >> 1; end
                4'h8: begin loss |= a[15] ^ a[14]; a = {a[15], a[13:0], b[14]}; b = {1'b0, b[13:0], 1'b0}; end
                4'h9: begin v = a[15]; a = {a[14:0], b[15]}; b = b << 1; end
                4'ha: begin b = {b[15], a[0], b[14:1]}; a = {a[15], a[15:1]}; end
                4'hb: begin v = b[0]; b = {a[0], b[15:1]}; a = a >> 1; end
                4'hc: begin a = {a[14:0], a[15]}; v = a[0]; end
                4'hd: begin b = {b[14:0], b[15]}; v = b[0]; end
                4'he: begin a = {a[14:0], b[15]}; b = {b[14:0], t[15]}; v = b[0]; end
                default: ;
            endcase
        end
        if (op == 4'h0 || op == 4'h4 || op == 4'h8) v = loss;
        else if (op == 4'h2 || op == 4'h6 || op == 4'ha) v = 1'b0;
        return {a, b, v};
    endfunction

    // One transfer: expectation from the effective field, then compare
    task automatic run(input logic idx, input logic [8:0] ins, input logic [8:0] ixr,
                       input logic [15:0] a, input logic [15:0] b, input logic v);
        logic [8:0] f;
        int k;
        int n;
        int cycles;
        logic bok;
        f = idx ? ins + ixr : ins;
        n = f[4:0];
        k = (f[8:5] == 4'h8 || f[8:5] == 4'he) ? 3 :
            (f[8:5] inside {4'h0, 4'h4, 4'h9, 4'ha, 4'hb}) ? 2 : 1;
        if (f[8:5] == 4'hf || n == 0) k = 0;
        u_cu.issue(idx, ins, ixr, a, b, v, cycles, bok);
        check("cycles", 36'(5 + k * n), 36'(cycles));
        check("busy", 36'h1, {35'h0, bok});
        check("result", {3'h0, ref_op(f[8:5], n, a, b, v)}, {3'h0, acc_a_o, acc_b_o, ovf_o});
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_in);
        #1;
        check("reset outputs", 36'h0, {1'b0, acc_a_o, acc_b_o, ovf_o, busy, done});
        rst_n_in = 1'b1;
        for (int op = 0; op < 16; op++) begin
            for (int c = 0; c < 4; c++) begin
                for (int p = 0; p < 3; p++) begin
                    run(1'b0, {op[3:0], cnts[c][4:0]}, 9'h000, pa[p], pb[p], p[0]);
                end
            end
        end
        run(1'b1, 9'h1fe, 9'h023, 16'h8001, 16'h1234, 1'b0);
        run(1'b1, 9'h01f, 9'h003, 16'hc001, 16'h1234, 1'b0);
        run(1'b1, 9'h1e1, 9'h1e3, 16'h8001, 16'h4321, 1'b1);
        wrap_up();
    end
endmodule // tb
